// >>> rtl/nvcfg_pkg.sv
// Purpose: shared constants of the stored configuration bank
// Assumes: 100 MHz system clock
// Notes:   offsets are the serial port's register addresses
`default_nettype none
package nvcfg_pkg;
  // register addresses
  localparam logic [7:0] OFF_GATE_LEVEL = 8'h15;
  localparam logic [7:0] OFF_CONFIG     = 8'h17;
  localparam logic [7:0] OFF_DELAYS     = 8'h18;
  localparam logic [7:0] OFF_ROOM_LEVEL = 8'h19;
  // values after reset
  localparam logic [5:0] GATE_LEVEL_RESET = 6'h16;
  localparam logic [7:0] STORED_RESET     = 8'h00;
  // serial port address, value is arbitrary
  localparam logic [6:0] PORT_ADDRESS = 7'h2A;
  // stored configuration field positions
  localparam int CFG_ONCHIP_BIT = 7;
  localparam int CFG_SPREAD_BIT = 5;
  localparam int CFG_RETRY_LSB  = 2;
  localparam int CFG_TIMER_LSB  = 0;
  // stored delay register field positions
  localparam int DLY_FIRST_LSB  = 6;
  localparam int DLY_SECOND_LSB = 4;
  localparam int DLY_THIRD_LSB  = 2;
  localparam int DLY_COMP_BIT   = 1;
  localparam int DLY_ROOM_BIT   = 0;
  // negative gate supply decode, millivolts
  localparam int GATE_BASE_MV = -5600;
  localparam int GATE_STEP_MV = 200;
  // start-up delay step
  localparam int CLK_FREQ_KHZ      = 100000;
  localparam int DELAY_STEP_MS     = 5;
  localparam int DELAY_STEP_CYCLES = DELAY_STEP_MS * CLK_FREQ_KHZ;
  localparam int SEQ_CNT_W         = 24;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage
`default_nettype wire

// >>> rtl/nv_shadow_mem.sv
// Purpose: shadow copies of the stored bytes with a registered read port
// Assumes: load strobe comes from the non-volatile loader on clk_i
// Notes:   no write path from software exists at all
`timescale 1ns/1ps
`default_nettype none
module nv_shadow_mem (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // loader side
  input  wire logic       load_i,
  input  wire logic [7:0] config_i,
  input  wire logic [7:0] delays_i,
  input  wire logic [7:0] room_i,
  // read port
  input  wire logic [7:0] addr_i,
  output logic      [7:0] rdata_o,
  // stored copies
  output logic      [7:0] config_o,
  output logic      [7:0] delays_o,
  output logic      [7:0] room_o
);
  import nvcfg_pkg::*;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] dly;
    logic [7:0] room;
    logic [7:0] rdata;
  } mem_state_t;

  mem_state_t q;
  mem_state_t d;

  always_comb begin
    d = q;
    if (load_i) begin
      d.cfg  = config_i;
      d.dly  = delays_i;
      d.room = room_i;
    end
    // unmapped addresses read as zero
    unique case (addr_i)
      OFF_CONFIG:     d.rdata = q.cfg;
      OFF_DELAYS:     d.rdata = q.dly;
      OFF_ROOM_LEVEL: d.rdata = q.room;
      default:        d.rdata = STORED_RESET;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= '{cfg: STORED_RESET, dly: STORED_RESET,
             room: STORED_RESET, rdata: STORED_RESET};
    end else begin
      q <= d;
    end
  end

  assign rdata_o  = q.rdata;
  assign config_o = q.cfg;
  assign delays_o = q.dly;
  assign room_o   = q.room;
endmodule
`default_nettype wire

// >>> rtl/stored_config_shadow_regs.sv
// Purpose: stored configuration bank, gate level and start-up sequencer
// Assumes: serial control port with scl/sda pins, one 100 MHz clock
// Notes:   pointer auto-increments after every data byte
//
// Behaviour
// - gate code maps linearly, -5.6 V at zero, 0.2 V lower per step.
// - config bit 7 high selects the on-chip thermometer, else external.
// - config bit 5 high turns on spread-spectrum clocking.
// - config bits 3:2 pick the waiting time before a fault retry.
// - delay fields 7:6, 5:4, 3:2 pick t1..t3 as 0, 5, 10 or 15 ms.
// - delay bit 1 high enables thermal compensation of common buffer.
// - room common level is its own byte, delay bit 0 its extra lsb.
`timescale 1ns/1ps
`default_nettype none
module stored_config_shadow_regs #(
  parameter int unsigned STEP_CYCLES = nvcfg_pkg::DELAY_STEP_CYCLES
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // serial control port pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // non-volatile loader
  input  wire logic       nv_load_i,
  input  wire logic [7:0] stored_config_i,
  input  wire logic [7:0] nv_delays_i,
  input  wire logic [7:0] nv_room_i,
  // power-up request
  input  wire logic       power_up_i,
  // decoded settings
  output logic     [15:0] negative_gate_mv_o,
  output logic            use_onchip_thermometer_o,
  output logic            spread_clock_enable_o,
  output logic      [1:0] fault_retry_time_o,
  output logic      [1:0] fault_timer_select_o,
  output logic      [1:0] startup_delay_first_o,
  output logic      [1:0] startup_delay_second_o,
  output logic      [1:0] startup_delay_third_o,
  output logic            thermal_comp_enable_o,
  output logic      [8:0] common_level_room_o,
  // start-up rail enables
  output logic      [2:0] rail_enable_o
);
  import nvcfg_pkg::*;

  typedef enum logic [3:0] {
    IDLE, ADDR, ACK_ADDR, REG, ACK_REG, WDATA, ACK_DATA, RDATA, RD_ACK
  } port_st_t;

  typedef struct packed {
    logic                 scl_s1;
    logic                 scl_s2;
    logic                 scl_s3;
    logic                 sda_s1;
    logic                 sda_s2;
    logic                 sda_s3;
    port_st_t             st;
    logic [3:0]           bit_cnt;
    logic [7:0]           shift;
    logic                 rw;
    logic                 nack;
    logic [7:0]           ptr;
    logic                 oe;
    logic [5:0]           gate_code;
    logic [15:0]          gate_mv;
    logic                 pwr_seen;
    logic [1:0]           phase;
    logic [SEQ_CNT_W-1:0] seq_cnt;
    logic [2:0]           rails;
  } state_t;

  state_t     q;
  state_t     d;
  logic [7:0] mem_rdata;
  logic [7:0] cfg;
  logic [7:0] dly;
  logic [7:0] room;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic [7:0] readback;
  logic [1:0] cur_field;
  logic [SEQ_CNT_W-1:0] target;

  nv_shadow_mem u_mem (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .load_i    (nv_load_i),
    .config_i  (stored_config_i),
    .delays_i  (nv_delays_i),
    .room_i    (nv_room_i),
    .addr_i    (q.ptr),
    .rdata_o   (mem_rdata),
    .config_o  (cfg),
    .delays_o  (dly),
    .room_o    (room)
  );

  // edges come from the settled stages only
  assign scl_rise   = q.scl_s2 & ~q.scl_s3;
  assign scl_fall   = ~q.scl_s2 & q.scl_s3;
  assign start_cond = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
  assign stop_cond  = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
  // stored bytes read from the shadow copies
  assign readback = (q.ptr == OFF_GATE_LEVEL) ? {2'b00, q.gate_code}
                                              : mem_rdata;

  always_comb begin
    unique case (q.phase)
      2'd0:    cur_field = dly[DLY_FIRST_LSB +: 2];
      2'd1:    cur_field = dly[DLY_SECOND_LSB +: 2];
      default: cur_field = dly[DLY_THIRD_LSB +: 2];
    endcase
    target = SEQ_CNT_W'(32'(cur_field) * STEP_CYCLES);
  end

  always_comb begin
    d = q;
    d.scl_s1 = scl_i;
    d.scl_s2 = q.scl_s1;
    d.scl_s3 = q.scl_s2;
    d.sda_s1 = sda_i;
    d.sda_s2 = q.sda_s1;
    d.sda_s3 = q.sda_s2;
    if (start_cond) begin
      d.st      = ADDR;
      d.bit_cnt = '0;
      d.oe      = 1'b0;
    end else if (stop_cond) begin
      d.st = IDLE;
      d.oe = 1'b0;
    end else begin
      unique case (q.st)
        IDLE: d.oe = 1'b0;
        ADDR, REG, WDATA: begin
          if (scl_rise && q.bit_cnt != BITS_PER_BYTE) begin
            d.shift   = {q.shift[6:0], q.sda_s2};
            d.bit_cnt = q.bit_cnt + 4'h1;
          end else if (scl_fall && q.bit_cnt == BITS_PER_BYTE) begin
            d.oe = 1'b1;
            if (q.st == ADDR) begin
              d.rw = q.shift[0];
              if (q.shift[7:1] == PORT_ADDRESS) begin
                d.st = ACK_ADDR;
              end else begin
                d.st = IDLE;
                d.oe = 1'b0;
              end
            end else if (q.st == REG) begin
              d.ptr = q.shift;
              d.st  = ACK_REG;
            end else begin
              // stored bytes have no write path
              if (q.ptr == OFF_GATE_LEVEL) begin
                d.gate_code = q.shift[5:0];
              end
              d.ptr = q.ptr + 8'h01;
              d.st  = ACK_DATA;
            end
          end
        end
        ACK_ADDR, ACK_REG, ACK_DATA: begin
          if (scl_fall) begin
            d.bit_cnt = '0;
            d.oe      = 1'b0;
            if (q.st == ACK_ADDR && q.rw) begin
              d.st    = RDATA;
              d.shift = readback;
              d.oe    = ~readback[7];
            end else if (q.st == ACK_ADDR) begin
              d.st = REG;
            end else begin
              d.st = WDATA;
            end
          end
        end
        RDATA: begin
          if (scl_fall) begin
            d.bit_cnt = q.bit_cnt + 4'h1;
            d.shift   = {q.shift[6:0], 1'b0};
            if (q.bit_cnt == BITS_PER_BYTE - 4'h1) begin
              d.oe  = 1'b0;
              d.st  = RD_ACK;
              d.ptr = q.ptr + 8'h01;
            end else begin
              d.oe = ~q.shift[6];
            end
          end
        end
        RD_ACK: begin
          if (scl_rise) begin
            d.nack = q.sda_s2;
          end else if (scl_fall) begin
            d.bit_cnt = '0;
            if (q.nack) begin
              d.st = IDLE;
            end else begin
              d.st    = RDATA;
              d.shift = readback;
              d.oe    = ~readback[7];
            end
          end
        end
      endcase
    end
    d.gate_mv = 16'(GATE_BASE_MV - GATE_STEP_MV * int'(q.gate_code));
    // sequencer restarts whenever the request drops
    d.pwr_seen = power_up_i;
    if (!power_up_i) begin
      d.phase   = 2'd0;
      d.seq_cnt = '0;
      d.rails   = 3'b000;
    end else if (!q.pwr_seen) begin
      d.phase   = 2'd0;
      d.seq_cnt = '0;
    end else if (q.rails != 3'b111) begin
      if (q.seq_cnt >= target) begin
        d.rails[q.phase] = 1'b1;
        d.seq_cnt        = '0;
        if (q.phase != 2'd2) begin
          d.phase = q.phase + 2'd1;
        end
      end else begin
        d.seq_cnt = q.seq_cnt + SEQ_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q           <= '0;
      q.scl_s1    <= 1'b1;
      q.scl_s2    <= 1'b1;
      q.scl_s3    <= 1'b1;
      q.sda_s1    <= 1'b1;
      q.sda_s2    <= 1'b1;
      q.sda_s3    <= 1'b1;
      q.st        <= IDLE;
      q.gate_code <= GATE_LEVEL_RESET;
      q.gate_mv   <= 16'(GATE_BASE_MV
                         - GATE_STEP_MV * int'(GATE_LEVEL_RESET));
    end else begin
      q <= d;
    end
  end

  // open drain: only ever pulls low
  assign sda_o                    = 1'b0;
  assign sda_oe_o                 = q.oe;
  assign negative_gate_mv_o       = q.gate_mv;
  assign use_onchip_thermometer_o = cfg[CFG_ONCHIP_BIT];
  assign spread_clock_enable_o    = cfg[CFG_SPREAD_BIT];
  assign fault_retry_time_o       = cfg[CFG_RETRY_LSB +: 2];
  assign fault_timer_select_o     = cfg[CFG_TIMER_LSB +: 2];
  assign startup_delay_first_o    = dly[DLY_FIRST_LSB +: 2];
  assign startup_delay_second_o   = dly[DLY_SECOND_LSB +: 2];
  assign startup_delay_third_o    = dly[DLY_THIRD_LSB +: 2];
  assign thermal_comp_enable_o    = dly[DLY_COMP_BIT];
  assign common_level_room_o      = {room, dly[DLY_ROOM_BIT]};
  assign rail_enable_o            = q.rails;
endmodule
`default_nettype wire

// >>> testbench/nvcfg_checker.sv
// Purpose: port assertions of the stored configuration bank
// Assumes: one clock, asynchronous active-low reset
// Notes:   gate code is hidden, so only its decoded grid is checked
`timescale 1ns/1ps
`default_nettype none
module nvcfg_checker (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  // loader
  input wire logic        nv_load_i,
  input wire logic  [7:0] stored_config_i,
  input wire logic  [7:0] nv_delays_i,
  input wire logic  [7:0] nv_room_i,
  // decoded settings
  input wire logic [15:0] negative_gate_mv_o,
  input wire logic        use_onchip_thermometer_o,
  input wire logic        spread_clock_enable_o,
  input wire logic  [1:0] fault_retry_time_o,
  input wire logic  [1:0] startup_delay_first_o,
  input wire logic  [1:0] startup_delay_second_o,
  input wire logic  [1:0] startup_delay_third_o,
  input wire logic        thermal_comp_enable_o,
  input wire logic  [8:0] common_level_room_o,
  // start-up sequencer
  input wire logic        power_up_i,
  input wire logic  [2:0] rail_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // hidden code, so only the 0.2 V grid and its ends can be seen
  property p_gate;
    $signed(negative_gate_mv_o) inside {[-18200:-5600]} &&
    $signed(negative_gate_mv_o) % 200 == 0;
  endproperty
  a_gate: assert property (p_gate) else $error("gate level off grid");
  property p_onchip;
    nv_load_i |=> use_onchip_thermometer_o == $past(stored_config_i[7]);
  endproperty
  a_onchip: assert property (p_onchip) else $error("sensor select");
  property p_spread;
    nv_load_i |=> spread_clock_enable_o == $past(stored_config_i[5]);
  endproperty
  a_spread: assert property (p_spread) else $error("spread enable");
  property p_retry;
    nv_load_i |=> fault_retry_time_o == $past(stored_config_i[3:2]);
  endproperty
  a_retry: assert property (p_retry) else $error("retry time");
  property p_delays;
    nv_load_i |=> {startup_delay_first_o, startup_delay_second_o,
                   startup_delay_third_o} == $past(nv_delays_i[7:2]);
  endproperty
  a_delays: assert property (p_delays) else $error("start delays");
  property p_comp;
    nv_load_i |=> thermal_comp_enable_o == $past(nv_delays_i[1]);
  endproperty
  a_comp: assert property (p_comp) else $error("comp enable");
  property p_room;
    nv_load_i |=> common_level_room_o ==
                  {$past(nv_room_i), $past(nv_delays_i[0])};
  endproperty
  a_room: assert property (p_room) else $error("room level");
  property p_hold;
    !nv_load_i |=> $stable({use_onchip_thermometer_o, fault_retry_time_o,
                   startup_delay_first_o, common_level_room_o});
  endproperty
  a_hold: assert property (p_hold) else $error("stored copy moved");
  property p_rails_off;
    !power_up_i |=> rail_enable_o == 3'h0;
  endproperty
  a_rails_off: assert property (p_rails_off) else $error("rails on");
endmodule
bind stored_config_shadow_regs nvcfg_checker nvcfg_checker_inst (.*);
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: self-checking bench of the stored configuration bank
// Assumes: scl half period of 10 clocks, start-up step of 10 clocks
// Notes:   results queue up and are compared one per clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nvcfg_pkg::*;
  localparam int S = 10;
  logic        clk_i = 0, reset_n_i = 0, scl_i = 1, sda_m = 1;
  logic        nv_load_i = 0, power_up_i = 0, ack_s, sda_o, sda_oe_o;
  logic  [7:0] stored_config_i = 0, nv_delays_i = 0, nv_room_i = 0, v, w;
  logic [15:0] negative_gate_mv_o;
  logic        use_onchip_thermometer_o, spread_clock_enable_o;
  logic        thermal_comp_enable_o;
  logic  [1:0] fault_retry_time_o, fault_timer_select_o;
  logic  [1:0] startup_delay_first_o, startup_delay_second_o;
  logic  [1:0] startup_delay_third_o;
  logic  [8:0] common_level_room_o;
  logic  [2:0] rail_enable_o;
  int          err_count = 0, checked = 0, cycles = 0, n;
  int          f[3] = '{1, 3, 0};
  string       nq[$];
  logic [31:0] eq[$], sq[$];
  // open-drain wire with pull-up
  wire logic   sda_w = sda_m & (sda_oe_o ? sda_o : 1'b1);
  stored_config_shadow_regs #(.STEP_CYCLES(S)) stored_config_shadow_regs_inst (
    .sda_i(sda_w), .*);
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic put(input string s, input logic [31:0] e, o);
    nq.push_back(s);
    eq.push_back(e);
    sq.push_back(o);
  endtask
  task automatic check(input string s, input logic [31:0] e, o);
    checked++;
    if (o !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", s, e, o);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // data moves only while scl is low
  task automatic bit_x(input logic b, output logic r);
    sda_m <= b;
    cyc(5);
    scl_i <= 1;
    cyc(5);
    r = sda_w;
    cyc(5);
    scl_i <= 0;
    cyc(5);
  endtask
  task automatic start_c;
    sda_m <= 1;
    cyc(5);
    scl_i <= 1;
    cyc(5);
    sda_m <= 0;
    cyc(5);
    scl_i <= 0;
    cyc(5);
  endtask
  task automatic stop_c;
    sda_m <= 0;
    cyc(5);
    scl_i <= 1;
    cyc(5);
    sda_m <= 1;
    cyc(5);
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(1'b1, ack_s);
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    start_c;
    xfer({PORT_ADDRESS, 1'b0}, q);
    xfer(a, q);
    xfer(d, q);
    put("wr_ack", 0, ack_s);
    stop_c;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    start_c;
    xfer({PORT_ADDRESS, 1'b0}, d);
    xfer(a, d);
    start_c;
    xfer({PORT_ADDRESS, 1'b1}, d);
    xfer(8'hFF, d);
    stop_c;
  endtask
  // master acks the first byte, so the pointer must step on by itself
  task automatic rd2(input logic [7:0] a, output logic [7:0] d0, d1);
    start_c;
    xfer({PORT_ADDRESS, 1'b0}, d0);
    xfer(a, d0);
    start_c;
    xfer({PORT_ADDRESS, 1'b1}, d0);
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d0[i]);
    bit_x(1'b0, ack_s);
    xfer(8'hFF, d1);
    stop_c;
  endtask
  task automatic gate(input logic [5:0] c);
    int g;
    g = -5600 - 200 * int'(c);
    wr(OFF_GATE_LEVEL, {2'b11, c});
    put("mv", {16'h0, g[15:0]}, {16'h0, negative_gate_mv_o});
    rd(OFF_GATE_LEVEL, v);
    put("rd_gate", {2'b00, c}, v);
  endtask
  task automatic load(input logic [7:0] c, d, r);
    stored_config_i <= c;
    nv_delays_i <= d;
    nv_room_i <= r;
    nv_load_i <= 1;
    cyc(1);
    nv_load_i <= 0;
    cyc(2);
    put("cfg", {c[7], c[5], c[3:0]}, {use_onchip_thermometer_o,
        spread_clock_enable_o, fault_retry_time_o,
        fault_timer_select_o});
    put("dly", d[7:1], {startup_delay_first_o, startup_delay_second_o,
        startup_delay_third_o, thermal_comp_enable_o});
    put("room", {r, d[0]}, common_level_room_o);
    wr(OFF_CONFIG, ~c);
    rd(OFF_CONFIG, v);
    put("rd_cfg", c, v);
    rd2(OFF_DELAYS, v, w);
    put("rd_dly", d, v);
    put("rd_room", r, w);
  endtask
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (sq.size() > 0) check(nq.pop_front(), eq.pop_front(), sq.pop_front());
    if (cycles == 80000) begin
      err_count++;
      print_verdict;
    end
  end
  initial begin
    void'($urandom(70133));
    cyc(10);
    reset_n_i <= 1;
    cyc(4);
    put("mv_rst", 32'h0000D8F0, {16'h0, negative_gate_mv_o});
    gate(6'h00);
    gate(6'h3F);
    gate(6'($urandom));
    load(8'hFF, 8'hFF, 8'hFF);
    load(8'h00, 8'h00, 8'h00);
    load(8'($urandom), 8'($urandom), 8'($urandom));
    rd(8'h40, v);
    put("rd_unmapped", 0, v);
    // wrong address must stay unanswered
    start_c;
    xfer({~PORT_ADDRESS, 1'b0}, v);
    put("bad_ack", 1, ack_s);
    stop_c;
    load(8'h00, 8'h70, 8'h00);
    power_up_i <= 1;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      while (rail_enable_o[k] !== 1'b1 && n < 200) begin
        cyc(1);
        n++;
      end
      put("rail_gap", 1, n >= f[k] * S && n <= f[k] * S + 4);
    end
    power_up_i <= 0;
    cyc(2);
    put("rails_off", 0, rail_enable_o);
    // mid-run reset brings back the start values
    reset_n_i <= 0;
    cyc(3);
    reset_n_i <= 1;
    cyc(4);
    put("mv_rst2", 32'h0000D8F0, {16'h0, negative_gate_mv_o});
    put("dly_rst", 0, {startup_delay_first_o, startup_delay_second_o});
    cyc(6);
    print_verdict;
  end
endmodule
`default_nettype wire
